// >>> common/ddct_map.vh
`ifndef DDCT_MAP_VH
`define DDCT_MAP_VH

// register addresses, 9-bit register port
`define DDCT_ADDR_SYNC_CONTROL 9'h100
`define DDCT_ADDR_FILTER_CONTROL 9'h102
`define DDCT_ADDR_HALFBAND_CONTROL 9'h103
`define DDCT_ADDR_TUNER_CONTROL 9'h11d
`define DDCT_ADDR_TUNING_WORD_BYTE_A 9'h11e
`define DDCT_ADDR_TUNING_WORD_BYTE_B 9'h11f
`define DDCT_ADDR_TUNING_WORD_BYTE_C 9'h120
`define DDCT_ADDR_TUNING_WORD_BYTE_D 9'h121
`define DDCT_ADDR_PHASE_OFFSET_BYTE_A 9'h122
`define DDCT_ADDR_PHASE_OFFSET_BYTE_B 9'h123
`define DDCT_ADDR_CHAIN_STATUS 9'h124

// field positions
`define DDCT_BIT_SYNC_FIRST_ONLY 3
`define DDCT_BIT_SYNC_ENABLE 4
`define DDCT_BIT_FIR_ENABLE 0
`define DDCT_BIT_XLAT_ENABLE 1
`define DDCT_BIT_HB_HIGHPASS 1
`define DDCT_BIT_TUNER_ENABLE 0
`define DDCT_BIT_AMP_DITHER 1
`define DDCT_BIT_PHASE_DITHER 2

// reset values
`define DDCT_RESET_BYTE 8'h00
`define DDCT_LFSR_SEED 16'h0001

`endif

// >>> design/ddct_trig_lut.v
`timescale 1ns/1ps
// cosine and sine from a 6-bit phase; quarter-wave table mirrored by quadrant
module ddct_trig_lut (
   input wire clk_in,
   input wire rst_n_in,
   input wire [5:0] phase_in,
   input wire dither_bit_in,
   output reg signed [11:0] cos_out,
   output reg signed [11:0] sin_out
);

   // half-step sample points keep the table free of a zero and a full-scale entry
   function [10:0] ddct_quarter;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: ddct_quarter = 11'd100;
            4'h1: ddct_quarter = 11'd300;
            4'h2: ddct_quarter = 11'd497;
            4'h3: ddct_quarter = 11'd690;
            4'h4: ddct_quarter = 11'd875;
            4'h5: ddct_quarter = 11'd1052;
            4'h6: ddct_quarter = 11'd1219;
            4'h7: ddct_quarter = 11'd1375;
            4'h8: ddct_quarter = 11'd1517;
            4'h9: ddct_quarter = 11'd1644;
            4'ha: ddct_quarter = 11'd1756;
            4'hb: ddct_quarter = 11'd1850;
            4'hc: ddct_quarter = 11'd1927;
            4'hd: ddct_quarter = 11'd1986;
            4'he: ddct_quarter = 11'd2025;
            default: ddct_quarter = 11'd2045;
         endcase
      end
   endfunction

   // full-circle sine from quadrant and index, used for both outputs
   function signed [11:0] ddct_sine;
      input [5:0] ph;
      reg [10:0] mag;
      begin
         mag = ph[4] ? ddct_quarter(~ph[3:0]) : ddct_quarter(ph[3:0]);
         ddct_sine = ph[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
      end
   endfunction

   wire [5:0] cos_phase;
   assign cos_phase = phase_in + 6'h10;

   // amplitude dither toggles the lsb; table peak 2045 leaves room for it
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cos_out <= 12'sh000;
         sin_out <= 12'sh000;
      end else begin
         cos_out <= ddct_sine(cos_phase) ^ {11'h000, dither_bit_in}; // [RULE18]
         sin_out <= ddct_sine(phase_in) ^ {11'h000, dither_bit_in}; // [RULE18]
      end
   end

endmodule

// >>> design/ddct_top.v
`timescale 1ns/1ps
// What this block does
// (RULE1) tuner, fir, translator each bypassable; half-band always
// (RULE2) five modes: hb real, hb+fir real, tuner+hb complex
// (RULE3) tuner, half-band, fir give complex output
// (RULE4) tuner, half-band, fir, translator give real output
// (RULE5) half-band outputs one sample per two
// (RULE6) half-band low-pass or high-pass response
// (RULE7) fir sharpens roll-off, removes negative images
// (RULE8) translator shifts dc up to eighth rate
// (RULE9) one oscillator shared by both channels
// (RULE10) tuner mixes real samples to complex, 32-bit
// (RULE11) tuner control bit 0 enables tuner
// (RULE12) tuning word from four byte registers
// (RULE13) tuning word is signed fraction of clock
// (RULE14) sync on every pulse or first after write
// (RULE15) valid sync restarts accumulator at phase offset
// (RULE16) 16-bit unsigned phase offset added to accumulator
// (RULE17) phase offset linear, full circle over 2^16
// (RULE18) tuner control bit 1 enables amplitude dither
// (RULE19) phase dither also available for the oscillator
// (RULE20) halfband control bit 1 selects high-pass
// (RULE21) filter control bit 0 enables fir
// (RULE22) accumulator adds word each clock, wraps 2^32
// (RULE23) bypassed tuner passes real samples, quadrature zero
`include "ddct_map.vh"

module ddct_top (
   input wire clk_in,
   input wire arst_n_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [8:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   input wire sync_in,
   input wire signed [13:0] adc_a_in,
   input wire signed [13:0] adc_b_in,
   output reg out_valid_out,
   output reg out_complex_out,
   output reg signed [13:0] out_a_i_out,
   output reg signed [13:0] out_a_q_out,
   output reg signed [13:0] out_b_i_out,
   output reg signed [13:0] out_b_q_out
);

   // reset release through two flops; everything else uses rst_n
   reg rst_meta;
   reg rst_n;
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // control registers
   reg [7:0] sync_control;
   reg [7:0] filter_control;
   reg [7:0] halfband_control;
   reg [7:0] tuner_control;
   reg [7:0] tuning_word_byte_a;
   reg [7:0] tuning_word_byte_b;
   reg [7:0] tuning_word_byte_c;
   reg [7:0] tuning_word_byte_d;
   reg [7:0] phase_offset_byte_a;
   reg [7:0] phase_offset_byte_b;
   reg sync_armed;
   reg sync_seen;

   wire [31:0] tuning_word_value;
   wire [15:0] phase_offset_value;
   wire tuner_en;
   wire fir_en;
   wire xlat_en;
   wire hb_highpass;
   // byte a is the least significant byte of each word
   assign tuning_word_value = {tuning_word_byte_d, tuning_word_byte_c,
                               tuning_word_byte_b, tuning_word_byte_a}; // [RULE12]
   assign phase_offset_value = {phase_offset_byte_b, phase_offset_byte_a}; // [RULE16]
   assign tuner_en = tuner_control[`DDCT_BIT_TUNER_ENABLE]; // [RULE11]
   assign fir_en = filter_control[`DDCT_BIT_FIR_ENABLE]; // [RULE21]
   assign xlat_en = filter_control[`DDCT_BIT_XLAT_ENABLE]; // [RULE1]
   assign hb_highpass = halfband_control[`DDCT_BIT_HB_HIGHPASS]; // [RULE20]

   // register writes
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_control <= `DDCT_RESET_BYTE;
         filter_control <= `DDCT_RESET_BYTE;
         halfband_control <= `DDCT_RESET_BYTE;
         tuner_control <= `DDCT_RESET_BYTE;
         tuning_word_byte_a <= `DDCT_RESET_BYTE;
         tuning_word_byte_b <= `DDCT_RESET_BYTE;
         tuning_word_byte_c <= `DDCT_RESET_BYTE;
         tuning_word_byte_d <= `DDCT_RESET_BYTE;
         phase_offset_byte_a <= `DDCT_RESET_BYTE;
         phase_offset_byte_b <= `DDCT_RESET_BYTE;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `DDCT_ADDR_SYNC_CONTROL: sync_control <= reg_wdata_in;
            `DDCT_ADDR_FILTER_CONTROL: filter_control <= reg_wdata_in;
            `DDCT_ADDR_HALFBAND_CONTROL: halfband_control <= reg_wdata_in;
            `DDCT_ADDR_TUNER_CONTROL: tuner_control <= reg_wdata_in;
            `DDCT_ADDR_TUNING_WORD_BYTE_A: tuning_word_byte_a <= reg_wdata_in;
            `DDCT_ADDR_TUNING_WORD_BYTE_B: tuning_word_byte_b <= reg_wdata_in;
            `DDCT_ADDR_TUNING_WORD_BYTE_C: tuning_word_byte_c <= reg_wdata_in;
            `DDCT_ADDR_TUNING_WORD_BYTE_D: tuning_word_byte_d <= reg_wdata_in;
            `DDCT_ADDR_PHASE_OFFSET_BYTE_A: phase_offset_byte_a <= reg_wdata_in;
            `DDCT_ADDR_PHASE_OFFSET_BYTE_B: phase_offset_byte_b <= reg_wdata_in;
            default: sync_control <= sync_control;
         endcase
      end
   end

   // registered read data; unmapped addresses and write-only gaps read zero
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `DDCT_ADDR_SYNC_CONTROL: reg_rdata_out <= sync_control;
            `DDCT_ADDR_FILTER_CONTROL: reg_rdata_out <= filter_control;
            `DDCT_ADDR_HALFBAND_CONTROL: reg_rdata_out <= halfband_control;
            `DDCT_ADDR_TUNER_CONTROL: reg_rdata_out <= tuner_control;
            `DDCT_ADDR_TUNING_WORD_BYTE_A: reg_rdata_out <= tuning_word_byte_a;
            `DDCT_ADDR_TUNING_WORD_BYTE_B: reg_rdata_out <= tuning_word_byte_b;
            `DDCT_ADDR_TUNING_WORD_BYTE_C: reg_rdata_out <= tuning_word_byte_c;
            `DDCT_ADDR_TUNING_WORD_BYTE_D: reg_rdata_out <= tuning_word_byte_d;
            `DDCT_ADDR_PHASE_OFFSET_BYTE_A: reg_rdata_out <= phase_offset_byte_a;
            `DDCT_ADDR_PHASE_OFFSET_BYTE_B: reg_rdata_out <= phase_offset_byte_b;
            `DDCT_ADDR_CHAIN_STATUS: reg_rdata_out <= {6'h00, sync_seen, sync_armed};
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // sync qualification: rising edge of the sync pin, gated by the mode bits
   reg sync_last;
   wire sync_edge;
   wire sync_valid;
   wire ctrl_write;
   assign sync_edge = sync_in & ~sync_last;
   assign sync_valid = sync_edge & sync_control[`DDCT_BIT_SYNC_ENABLE] &
                       (~sync_control[`DDCT_BIT_SYNC_FIRST_ONLY] | sync_armed); // [RULE14]
   assign ctrl_write = reg_wr_in & (reg_addr_in == `DDCT_ADDR_SYNC_CONTROL);

   // a write re-arms first-only mode; the write wins over a same-cycle pulse for sync_armed, the pulse wins for sync_seen
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_last <= 1'b0;
         sync_armed <= 1'b0;
         sync_seen <= 1'b0;
      end else begin
         sync_last <= sync_in;
         if (ctrl_write) begin
            sync_armed <= 1'b1; // [RULE14]
         end else if (sync_valid) begin
            sync_armed <= 1'b0; // [RULE14]
         end
         if (sync_valid) begin
            sync_seen <= 1'b1;
         end else if (ctrl_write) begin
            sync_seen <= 1'b0;
         end
      end
   end

   // phase accumulator; modular 32-bit add makes the word two's complement
   reg [31:0] phase_acc;
   reg [15:0] lfsr;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         phase_acc <= 32'h00000000;
         lfsr <= `DDCT_LFSR_SEED;
      end else begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[14] ^ lfsr[12] ^ lfsr[3]};
         if (sync_valid) begin
            phase_acc <= 32'h00000000; // [RULE15] offset is added at the lookup
         end else begin
            phase_acc <= phase_acc + tuning_word_value; // [RULE22] [RULE13]
         end
      end
   end

   // offset in 1/65536 turns added to the top half; phase dither below the table index
   wire [15:0] phase_dither;
   wire [15:0] lookup_phase;
   assign phase_dither = tuner_control[`DDCT_BIT_PHASE_DITHER] ? {6'h00, lfsr[9:0]} : 16'h0000; // [RULE19]
   assign lookup_phase = phase_acc[31:16] + phase_offset_value + phase_dither; // [RULE16] [RULE17] [RULE22]

   wire signed [11:0] nco_cos;
   wire signed [11:0] nco_sin;
   // one lookup feeds both channels so they mix with identical phase
   ddct_trig_lut u_trig ( // [RULE9]
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .phase_in(lookup_phase[15:10]),
      .dither_bit_in(tuner_control[`DDCT_BIT_AMP_DITHER] & lfsr[15]), // [RULE18]
      .cos_out(nco_cos),
      .sin_out(nco_sin)
   );

   // samples delayed one cycle to line up with the registered lookup
   reg signed [13:0] adc_a_d;
   reg signed [13:0] adc_b_d;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         adc_a_d <= 14'sh0000;
         adc_b_d <= 14'sh0000;
      end else begin
         adc_a_d <= adc_a_in;
         adc_b_d <= adc_b_in;
      end
   end

   wire signed [25:0] prod_a_i;
   wire signed [25:0] prod_a_q;
   wire signed [25:0] prod_b_i;
   wire signed [25:0] prod_b_q;
   assign prod_a_i = adc_a_d * nco_cos; // [RULE10]
   assign prod_a_q = adc_a_d * nco_sin; // [RULE10]
   assign prod_b_i = adc_b_d * nco_cos; // [RULE10]
   assign prod_b_q = adc_b_d * nco_sin; // [RULE10]

   // mixer: lanes 0,1 are channel a i/q, lanes 2,3 channel b i/q, 16 bits each
   reg [63:0] mix_lanes;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         mix_lanes <= 64'h0000000000000000;
      end else if (tuner_en) begin
         mix_lanes <= {-{{2{prod_b_q[25]}}, prod_b_q[24:11]}, {{2{prod_b_i[25]}}, prod_b_i[24:11]},
                       -{{2{prod_a_q[25]}}, prod_a_q[24:11]}, {{2{prod_a_i[25]}}, prod_a_i[24:11]}};
      end else begin
         mix_lanes <= {16'h0000, {{2{adc_b_d[13]}}, adc_b_d},
                       16'h0000, {{2{adc_a_d[13]}}, adc_a_d}}; // [RULE23]
      end
   end

   // decimation phase: a result every second input sample
   reg dec_phase;
   reg hb_valid;
   reg fir_valid;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         dec_phase <= 1'b0;
         hb_valid <= 1'b0;
         fir_valid <= 1'b0;
      end else begin
         dec_phase <= ~dec_phase; // [RULE5]
         hb_valid <= dec_phase; // [RULE5]
         fir_valid <= hb_valid;
      end
   end

   wire [63:0] fir_lanes;
   genvar ln;
   generate
      for (ln = 0; ln < 4; ln = ln + 1) begin : g_lane
         // high-pass by flipping alternate input samples, mirroring the response
         wire signed [15:0] hb_in;
         assign hb_in = (hb_highpass & dec_phase) ? -$signed(mix_lanes[ln*16 +: 16])
                        : $signed(mix_lanes[ln*16 +: 16]); // [RULE6] [RULE1]
         reg signed [15:0] tap0, tap1, tap2, tap3, tap4, tap5, tap6;
         wire signed [21:0] hb_sum;
         // short half-band (-1,0,9,16,9,0,-1)/32; taps two away from centre are zero
         assign hb_sum = 22'sd9 * (tap2 + tap4) + 22'sd16 * tap3 - tap0 - tap6;
         reg signed [15:0] hb_out;
         reg signed [15:0] fir_d1, fir_d2;
         wire signed [17:0] fir_sum;
         // fixed (1,2,1)/4 smoother on the decimated stream, non-decimating
         assign fir_sum = hb_out + 18'sd2 * fir_d1 + fir_d2;
         reg signed [15:0] fir_out;
         always @(posedge clk_in or negedge rst_n) begin
            if (!rst_n) begin
               tap0 <= 16'sh0000; tap1 <= 16'sh0000; tap2 <= 16'sh0000; tap3 <= 16'sh0000;
               tap4 <= 16'sh0000; tap5 <= 16'sh0000; tap6 <= 16'sh0000;
               hb_out <= 16'sh0000;
               fir_d1 <= 16'sh0000;
               fir_d2 <= 16'sh0000;
               fir_out <= 16'sh0000;
            end else begin
               {tap0, tap1, tap2, tap3, tap4, tap5, tap6} <= {tap1, tap2, tap3, tap4, tap5, tap6, hb_in};
               if (dec_phase) begin
                  hb_out <= hb_sum[20:5]; // [RULE5]
               end
               if (hb_valid) begin
                  fir_d1 <= hb_out;
                  fir_d2 <= fir_d1;
                  fir_out <= fir_en ? fir_sum[17:2] : hb_out; // [RULE7] [RULE21]
               end
            end
         end
         assign fir_lanes[ln*16 +: 16] = fir_out;
      end
   endgenerate

   // quarter-output-rate rotation by j^n gives the real part of the shifted signal
   function signed [13:0] ddct_xlat;
      input signed [13:0] i_val;
      input signed [13:0] q_val;
      input [1:0] step;
      begin
         case (step)
            2'd0: ddct_xlat = i_val;
            2'd1: ddct_xlat = -q_val;
            2'd2: ddct_xlat = -i_val;
            default: ddct_xlat = q_val;
         endcase
      end
   endfunction

   // output stage; real modes carry zero on the q outputs
   reg [1:0] xlat_step;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         xlat_step <= 2'd0;
         out_valid_out <= 1'b0;
         out_complex_out <= 1'b0;
         out_a_i_out <= 14'sh0000;
         out_a_q_out <= 14'sh0000;
         out_b_i_out <= 14'sh0000;
         out_b_q_out <= 14'sh0000;
      end else begin
         out_valid_out <= fir_valid;
         if (fir_valid) begin
            xlat_step <= xlat_step + 2'd1;
            out_complex_out <= tuner_en & ~xlat_en; // [RULE2] [RULE3]
            if (xlat_en) begin
               out_a_i_out <= ddct_xlat(fir_lanes[13:0], fir_lanes[29:16], xlat_step); // [RULE8] [RULE4]
               out_b_i_out <= ddct_xlat(fir_lanes[45:32], fir_lanes[61:48], xlat_step); // [RULE8] [RULE4]
               out_a_q_out <= 14'sh0000;
               out_b_q_out <= 14'sh0000;
            end else begin
               out_a_i_out <= fir_lanes[13:0];
               out_b_i_out <= fir_lanes[45:32];
               out_a_q_out <= tuner_en ? fir_lanes[29:16] : 14'sh0000; // [RULE2] [RULE3]
               out_b_q_out <= tuner_en ? fir_lanes[61:48] : 14'sh0000; // [RULE2] [RULE3]
            end
         end
      end
   end

endmodule

// >>> verification/ddct_chk.sv
`timescale 1ns/1ps
// port-level checks of the register port and the output stream
module ddct_chk (
   input wire clk_in,
   input wire arst_n_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [8:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire [7:0] reg_rdata_out,
   input wire out_valid_out,
   input wire out_complex_out,
   input wire signed [13:0] out_a_i_out,
   input wire signed [13:0] out_a_q_out,
   input wire signed [13:0] out_b_i_out,
   input wire signed [13:0] out_b_q_out
);
   wire mapped_rw;
   // read-write bytes only; the status byte is read-only so it is left out
   assign mapped_rw = (reg_addr_in == 9'h100) || (reg_addr_in == 9'h102) || (reg_addr_in == 9'h103) ||
      ((reg_addr_in >= 9'h11d) && (reg_addr_in <= 9'h123));
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   a_valid_gap: assert property (out_valid_out |=> !out_valid_out)
      else $error("output valid high on two cycles in a row");
   a_valid_period: assert property (out_valid_out |-> ##2 out_valid_out)
      else $error("output sample missing two cycles after the last");
   a_hold_a: assert property (!out_valid_out |-> $stable(out_a_i_out) && $stable(out_a_q_out))
      else $error("channel a output moved between samples");
   a_hold_b: assert property (!out_valid_out |-> $stable(out_b_i_out) && $stable(out_b_q_out))
      else $error("channel b output moved between samples");
   a_real_q_zero: assert property (out_valid_out && !out_complex_out |-> out_a_q_out == 14'h0000)
      else $error("channel a quadrature not zero in real output");
   a_real_qb_zero: assert property (out_valid_out && !out_complex_out |-> out_b_q_out == 14'h0000)
      else $error("channel b quadrature not zero in real output");
   a_unmapped_zero: assert property (reg_rd_in && !mapped_rw && reg_addr_in != 9'h124 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read returned nonzero");
   a_write_readback: assert property ((reg_wr_in && mapped_rw) ##1 (reg_rd_in && reg_addr_in == $past(reg_addr_in))
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("read after write returned other data");
   a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");
endmodule

bind ddct_top ddct_chk u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .out_valid_out(out_valid_out), .out_complex_out(out_complex_out), .out_a_i_out(out_a_i_out),
   .out_a_q_out(out_a_q_out), .out_b_i_out(out_b_i_out), .out_b_q_out(out_b_q_out));

// >>> verification/ddct_adc_model.sv
`timescale 1ns/1ps
// converter cores feeding both channels plus a formatter that counts samples
module ddct_adc_model (
   input wire clk_in,
   input wire signed [13:0] level_in,
   input wire valid_in,
   output reg signed [13:0] adc_a_out,
   output reg signed [13:0] adc_b_out,
   output reg [15:0] n_valid_out
);
   initial begin
      adc_a_out = 14'h0000;
      adc_b_out = 14'h0000;
      n_valid_out = 16'h0000;
   end
   // same level on both lanes so a shared oscillator shows as equal outputs
   always @(negedge clk_in) begin
      adc_a_out <= level_in;
      adc_b_out <= level_in;
   end
   // formatter side takes every sample marked valid
   always @(posedge clk_in) begin
      if (valid_in === 1'b1) begin
         n_valid_out <= n_valid_out + 16'h0001;
      end
   end
endmodule

// >>> verification/ddct_top_tb.sv
`timescale 1ns/1ps
module ddct_top_tb;
   reg clk_in, arst_n_in, reg_wr_in, reg_rd_in, sync_in;
   reg [8:0] reg_addr_in;
   reg [7:0] reg_wdata_in, b;
   reg signed [13:0] level;
   wire [7:0] reg_rdata_out;
   wire out_valid_out, out_complex_out;
   wire signed [13:0] adc_a, adc_b, out_a_i, out_a_q, out_b_i, out_b_q;
   wire [15:0] n_valid;
   integer n_errors, total_checks, k, j, s;
   reg signed [13:0] v [0:3];
   reg [27:0] snap0;
   reg [15:0] cnt0;
   reg [8:0] addrs [0:9];
   // mode rows: filter control, tuner control, expected complex flag
   reg [16:0] rows [0:4];
   ddct_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .sync_in(sync_in),
      .adc_a_in(adc_a), .adc_b_in(adc_b), .out_valid_out(out_valid_out), .out_complex_out(out_complex_out),
      .out_a_i_out(out_a_i), .out_a_q_out(out_a_q), .out_b_i_out(out_b_i), .out_b_q_out(out_b_q));
   ddct_adc_model u_adc (.clk_in(clk_in), .level_in(level), .valid_in(out_valid_out), .adc_a_out(adc_a),
      .adc_b_out(adc_b), .n_valid_out(n_valid));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task results;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk8(input string name, input [7:0] exp, input [7:0] got);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task chks(input string name, input [27:0] exp, input [27:0] got);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task wr(input [8:0] a, input [7:0] d);
      @(negedge clk_in); reg_wr_in = 1'b1; reg_addr_in = a; reg_wdata_in = d;
      @(negedge clk_in); reg_wr_in = 1'b0;
   endtask
   // optional write immediately followed by a read of the same address
   task rd(input [8:0] a, input do_wr, input [7:0] d, output [7:0] q);
      @(negedge clk_in); reg_wr_in = do_wr; reg_addr_in = a; reg_wdata_in = d;
      if (do_wr) @(negedge clk_in);
      reg_wr_in = 1'b0; reg_rd_in = 1'b1;
      @(negedge clk_in); reg_rd_in = 1'b0;
      @(negedge clk_in); q = reg_rdata_out;
   endtask
   // sync held for two cycles so the rising edge is seen once
   task pulse;
      @(negedge clk_in); sync_in = 1'b1;
      repeat (2) @(negedge clk_in);
      sync_in = 1'b0;
      repeat (2) @(negedge clk_in);
   endtask
   initial begin
      #100000;
      n_errors = n_errors + 1;
      results;
   end
   initial begin
      n_errors = 0; total_checks = 0; arst_n_in = 1'b0; reg_wr_in = 1'b0; reg_rd_in = 1'b0; sync_in = 1'b0;
      reg_addr_in = 9'h000; reg_wdata_in = 8'h00; level = 14'sd1000;
      addrs[0] = 9'h100; addrs[1] = 9'h102; addrs[2] = 9'h103;
      for (k = 3; k < 10; k = k + 1) addrs[k] = 9'h11a + k;
      rows[0] = {8'h00, 8'h00, 1'b0}; rows[1] = {8'h01, 8'h00, 1'b0}; rows[2] = {8'h00, 8'h01, 1'b1};
      rows[3] = {8'h01, 8'h01, 1'b1}; rows[4] = {8'h03, 8'h01, 1'b0};
      repeat (2) @(posedge clk_in);
      @(negedge clk_in); arst_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
      for (k = 0; k < 10; k = k + 1) begin
         rd(addrs[k], 1'b0, 8'h00, b); chk8("reset value", 8'h00, b);
      end
      rd(9'h101, 1'b0, 8'h00, b); chk8("unmapped read", 8'h00, b);
      for (k = 0; k < 10; k = k + 1) begin
         rd(addrs[k], 1'b1, 8'ha5 ^ k[7:0], b); chk8("readback", 8'ha5 ^ k[7:0], b);
      end
      // first-only sync: armed by the write, one pulse taken, later ones refused
      rd(9'h100, 1'b1, 8'h18, b);
      rd(9'h124, 1'b0, 8'h00, b); chk8("armed", 8'h01, b);
      pulse;
      rd(9'h124, 1'b0, 8'h00, b); chk8("sync seen", 8'h02, b);
      rd(9'h124, 1'b1, 8'hff, b); chk8("status read only", 8'h02, b);
      pulse;
      rd(9'h124, 1'b0, 8'h00, b); chk8("second pulse refused", 8'h02, b);
      rd(9'h100, 1'b1, 8'h18, b);
      rd(9'h124, 1'b0, 8'h00, b); chk8("rearmed", 8'h01, b);
      // every-pulse sync restarts the oscillator; tuning word is an eighth turn per 2 cycles
      wr(9'h100, 8'h10); wr(9'h102, 8'h00); wr(9'h103, 8'h00); wr(9'h11d, 8'h01);
      wr(9'h11e, 8'h00); wr(9'h11f, 8'h00); wr(9'h120, 8'h00); wr(9'h121, 8'h10);
      wr(9'h122, 8'h00); wr(9'h123, 8'h00);
      for (j = 0; j < 3; j = j + 1) begin
         if (j == 2) wr(9'h123, 8'h40);
         else wr(9'h122, 8'h00);
         pulse;
         // even pass length keeps the decimation phase the same at every sync
         repeat (11) @(negedge clk_in);
         chks("shared oscillator", {out_a_i, out_a_q}, {out_b_i, out_b_q});
         if (j == 0) snap0 = {out_a_i, out_a_q};
         if (j == 1) chks("restart phase", snap0, {out_a_i, out_a_q});
         if (j == 2) chks("phase offset moves", 28'h1, {27'h0, snap0 !== {out_a_i, out_a_q}});
      end
      wr(9'h123, 8'h00);
      for (k = 0; k < 5; k = k + 1) begin
         wr(9'h102, rows[k][16:9]); wr(9'h11d, rows[k][8:1]);
         repeat (20) @(negedge clk_in);
         chks("complex flag", {27'h0, rows[k][0]}, {27'h0, out_complex_out});
         cnt0 = n_valid;
         repeat (40) @(negedge clk_in);
         chks("valid count", 28'd20, {12'h0, n_valid - cnt0});
      end
      // dc through the bypassed tuner and low-pass half-band, fir off then on
      for (k = 0; k < 2; k = k + 1) begin
         wr(9'h11d, 8'h00); wr(9'h102, k[7:0]);
         repeat (30) @(negedge clk_in);
         chks("dc passthrough", {14'h0000, 14'sd1000}, {out_a_q, out_a_i});
      end
      wr(9'h103, 8'h02);
      repeat (30) @(negedge clk_in);
      chks("high-pass blocks dc", 28'h1, {27'h0, out_a_i !== 14'sd1000});
      wr(9'h103, 8'h00); wr(9'h102, 8'h03);
      repeat (30) @(negedge clk_in);
      for (j = 0; j < 4; j = j + 1) begin
         @(negedge clk_in);
         while (out_valid_out !== 1'b1) @(negedge clk_in);
         v[j] = out_a_i;
      end
      s = (v[0] < 0 ? -v[0] : v[0]) + (v[1] < 0 ? -v[1] : v[1]);
      chks("translator opposite", 28'h0, v[0] + v[2]);
      chks("translator quadrature", 28'h0, v[1] + v[3]);
      chks("translator level", 28'd1000, s);
      results;
   end
endmodule
